// >>> sim/rtd_host_scan.sv
`timescale 1ns/100ps
module rtd_host_scan (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  wire logic [31:0] i_word,
    output logic             o_scan_strobe,
    output logic             o_done,
    output logic      [31:0] o_word
);
    // ------------------------------------------------------------------
    // Host scan: one strobe, then the whole word is read at once
    // ------------------------------------------------------------------
    logic cap_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_scan_strobe <= 1'b0;
            cap_q         <= 1'b0;
            o_done        <= 1'b0;
            o_word        <= 32'h0;
        end else begin
            o_scan_strobe <= i_req;
            cap_q         <= o_scan_strobe;
            o_done        <= cap_q;
            if (cap_q) o_word <= i_word;
        end
    end
endmodule : rtd_host_scan

// >>> sim/rtd_input_mux_sva.sv
`timescale 1ns/100ps
module rtd_input_mux_sva (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_scan_strobe,
    input wire logic        i_power_ok,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        o_avs_waitrequest,
    input wire logic [3:0]  o_chan_active,
    input wire logic [31:0] o_input_word,
    input wire logic        o_irq
);
    // ------------------------------------------------------------------
    // Port checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [1:0] id;
    assign id = o_input_word[17:16];
    wait_first_a: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
        else $error("request not stalled in its first cycle");
    wait_once_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("more than one wait state");
    word_pad_a: assert property (o_input_word[31:20] == 12'h0)
        else $error("unused word bits set");
    word_cause_a: assert property ($changed(o_input_word) |-> $past(i_scan_strobe))
        else $error("word changed without a scan");
    // Hold freezes the word, so a stable word also satisfies the rotation checks
    id_active_a: assert property ($past(i_scan_strobe) |-> o_chan_active[id])
        else $error("inactive channel shown");
    id_wrap_a: assert property (i_scan_strobe && (id == 2'h3 || !o_chan_active[2'(id + 2'h1)])
        |=> id == 2'h0 || $stable(o_input_word)) else $error("no wrap to first channel");
    id_step_a: assert property ($changed(id) |-> id == 2'($past(id) + 2'h1) || id == 2'h0)
        else $error("channel id skipped");
    power_flag_a: assert property (i_scan_strobe |=>
        o_input_word[19] == !$past(i_power_ok) || $stable(o_input_word))
        else $error("power fault bit wrong");
    chan_contig_a: assert property ((o_chan_active & (o_chan_active + 4'h1)) == 4'h0)
        else $error("active channels not contiguous");
    chan_fixed_a: assert property (o_chan_active != 4'h0 |=> $stable(o_chan_active))
        else $error("active set changed");
    cover property (i_scan_strobe && id == 2'h3);
    cover property (o_irq);
    cover property (i_avs_write && !o_avs_waitrequest);
endmodule : rtd_input_mux_sva

bind rtd_input_mux rtd_input_mux_sva rtd_input_mux_sva_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_scan_strobe(i_scan_strobe), .i_power_ok(i_power_ok),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .o_chan_active(o_chan_active), .o_input_word(o_input_word), .o_irq(o_irq));

// >>> sim/test_rtd_input_config_and_channel_mux.sv
`timescale 1ns/100ps
`include "rtd_mux_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module test_rtd_input_config_and_channel_mux;
    logic i_clk = 0, i_rst = 1, cnt_a = 1, cnt_b = 1, typ0 = 1, typ1 = 1, typ2 = 0;
    logic unit0 = 1, unit1 = 1, cv = 0, csh = 0, pw = 1, rd = 0, wr = 0, req = 0;
    logic [1:0]         cch = 0;
    logic signed [23:0] cdev = 0;
    logic [7:0]         adr = 0;
    logic [31:0]        wd = 0, rdata, word, hword, q;
    logic [3:0]         act, shq;
    logic               wait_hi, irq, strobe, done;
    logic [2:0]         cs, st [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [1:0]         cf;
    logic signed [23:0] dv [4] = '{24'sd403702, -24'sd100000, 24'sd0, 24'sd4000000};
    int                 fails = 0, compares = 0;
    always #25 i_clk = ~i_clk;
    rtd_input_mux #(.N_CHAN(4)) rtd_input_mux_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_chan_count_sel_a(cnt_a), .i_chan_count_sel_b(cnt_b), .i_sensor_type_sel_0(typ0),
        .i_sensor_type_sel_1(typ1), .i_sensor_type_sel_2(typ2), .i_units_sel_0(unit0),
        .i_units_sel_1(unit1), .i_conv_valid(cv), .i_conv_chan(cch), .i_conv_dev(cdev),
        .i_conv_short(csh), .i_power_ok(pw), .i_scan_strobe(strobe), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_hi), .o_chan_active(act),
        .o_input_word(word), .o_irq(irq));
    rtd_host_scan rtd_host_scan_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_word(word),
        .o_scan_strobe(strobe), .o_done(done), .o_word(hword));
    // ------------------------------------------------------------------
    // Expected data, worked out independently of the design
    // ------------------------------------------------------------------
    function automatic logic [15:0] temp(logic signed [23:0] d);
        longint t, a;
        a = (cs == 3'h2) ? 3920 : ((cs < 3'h2) ? 4270 : 3850);
        t = (longint'(d) * (64'sd2560000000 / a)) >>> 28;
        if (cf[0]) t = t * 9 / 5 + 320;
        if (t > 32767) t = 32767;
        if (t < -32767) t = -32767;
        temp = cf[1] ? {t < 0, 15'((t < 0) ? -t : t)} : 16'(t);
    endfunction : temp
    task automatic complete_run;
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Waits are open-ended; only the watchdog ends a dead handshake
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        do begin @(posedge i_clk); end while (wait_hi !== 1'b0);
        q = rdata;
        rd <= 0;
        wr <= 0;
        @(posedge i_clk);
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(0, a, 0);
        `CHK(nm, e, q)
    endtask : rdchk
    task automatic conv(input int c, input logic s);
        cch <= 2'(c); cdev <= dv[c]; csh <= s; cv <= 1; shq[c] = s;
        @(posedge i_clk);
        cv <= 0;
        @(posedge i_clk);
    endtask : conv
    task automatic scan(input int c, input logic p);
        req <= 1;
        @(posedge i_clk);
        req <= 0;
        do begin @(posedge i_clk); end while (done !== 1'b1);
        `CHK("word", {12'h0, p, shq[c], 2'(c), temp(dv[c])}, hword)
    endtask : scan
    task automatic reset_dut;
        i_rst <= 1;
        repeat (4) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
    endtask : reset_dut
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        cs = 3'h3; cf = 2'h3;
        reset_dut;
        rdchk(`RTD_OFS_CONFIG, 32'h6f, "config");
        `CHK("active", 4'hf, act)
        rdchk(8'h20, 32'h0, "unmapped");
        bus(1, `RTD_OFS_MASK, 32'h2);
        for (int c = 0; c < 4; c++) conv(c, c == 1);
        `CHK("irq", 1'b1, irq)
        rdchk(`RTD_OFS_STATUS, 32'h3, "status");
        `CHK("irq", 1'b0, irq)
        for (int k = 0; k < 5; k++) scan(k % 4, 0);
        pw <= 0;
        scan(1, 1);
        pw <= 1;
        bus(1, `RTD_OFS_CTRL, 32'h1);
        // Held rotation: a scan must leave word and pointer untouched
        scan(1, 1);
        rdchk(`RTD_OFS_WORD, {12'h0, 4'hd, temp(dv[1])}, "word reg");
        bus(1, `RTD_OFS_CTRL, 32'h0);
        scan(2, 0);
        rdchk(`RTD_OFS_STATUS, 32'hc, "events");
        for (int i = 0; i < 4; i++) begin
            {cnt_b, cnt_a} <= 2'(i); {unit1, unit0} <= 2'(i); {typ2, typ1, typ0} <= st[i];
            cs = st[i]; cf = 2'(i);
            reset_dut;
            rdchk(`RTD_OFS_CONFIG, {25'h0, cf, cs, 2'(i)}, "config");
            `CHK("active", 4'((5'h2 << i) - 5'h1), act)
            if (i < 3) begin
                bus(0, `RTD_OFS_STATUS, 0);
                conv(i + 1, 1);
                rdchk(`RTD_OFS_STATUS, 32'h0, "dropped");
            end
            for (int c = 0; c <= i; c++) conv(c, 0);
            for (int k = 0; k < i + 2; k++) scan(k % (i + 1), 0);
        end
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        fails++;
        complete_run;
    end
endmodule : test_rtd_input_config_and_channel_mux

// >>> verilog/rtd_input_mux.sv
// Contract
// (RULE1) Two count straps pick one, two, three or four channels; four by default.
// (RULE2) Channels above the selected count are neither converted nor reported.
// (RULE3) Three type straps pick copper 10, copper 25, American, European platinum 100 or platinum 1000.
// (RULE4) One sensor type applies to every channel.
// (RULE5) Factory sensor type is European platinum 100 with third strap absent.
// (RULE6) Platinum gains use 0.00385 European and 0.00392 American per degree.
// (RULE7) Two format straps pick sign-magnitude or two's complement, Fahrenheit or Celsius.
// (RULE8) Factory format is sign-magnitude Fahrenheit, both straps present.
// (RULE9) Every sensor type is converted to a direct temperature in chosen unit.
// (RULE10) Readings are integers in tenths of a degree.
// (RULE11) Negative readings set the word's top data bit; rest follows format.
// (RULE12) Exactly one channel is presented per host scan.
// (RULE13) After the last active channel the rotation wraps to channel one.
// (RULE14) Rotation skips inactive channels.
// (RULE15) Host places the module's input word on a 32-point boundary.
// (RULE16) Word holds fifteen magnitude bits, sign, two id bits, four fault bits.
// (RULE17) Input shorts and lost input power are reported in fault bits.
// (RULE18) Channel id bits name the channel whose reading fills the data bits.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "rtd_mux_regs.svh"

module rtd_input_mux #(
    parameter int N_CHAN = 4
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_chan_count_sel_a,
    input  wire logic        i_chan_count_sel_b,
    input  wire logic        i_sensor_type_sel_0,
    input  wire logic        i_sensor_type_sel_1,
    input  wire logic        i_sensor_type_sel_2,
    input  wire logic        i_units_sel_0,
    input  wire logic        i_units_sel_1,
    input  wire logic        i_conv_valid,
    input  wire logic [1:0]  i_conv_chan,
    input  wire logic [23:0] i_conv_dev,
    input  wire logic        i_conv_short,
    input  wire logic        i_power_ok,
    input  wire logic        i_scan_strobe,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic      [3:0]  o_chan_active,
    output logic      [31:0] o_input_word,
    output logic             o_irq
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Two id bits in the host word cannot name more than four channels
    if (N_CHAN < 1 || N_CHAN > 4) begin : g_bad_chan
        $error("N_CHAN must be between 1 and 4");
    end

    localparam logic [1:0] MAX_LAST = 2'(N_CHAN - 1);

    rtd_mux_pkg::rtd_state_s s_q;
    rtd_mux_pkg::rtd_state_s s_d;

    logic [15:0] conv_data;
    logic [1:0]  strap_last;
    logic [1:0]  next_ptr;
    logic        wrap;
    logic        take;
    logic        take_rd;
    logic        take_wr;
    logic [3:0]  events;
    logic [3:0]  fault;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------------
    // Converter shared by all channels
    // ------------------------------------------------------------------------
    rtd_temp_convert u_convert (
        .i_dev    (i_conv_dev),
        .i_sensor (s_q.sensor),
        .i_fmt    (s_q.fmt),
        .o_data   (conv_data)
    );

    // ------------------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------------------
    always_comb begin
        // Count straps map straight onto the index of the last channel
        strap_last = {i_chan_count_sel_b, i_chan_count_sel_a};  // [RULE1]
        if (strap_last > MAX_LAST) begin
            strap_last = MAX_LAST;
        end
        // Rotation runs 0..last only, so inactive channels are never visited
        wrap     = (s_q.ptr >= s_q.chan_last);  // [RULE14]
        next_ptr = wrap ? 2'h0 : s_q.ptr + 2'h1;  // [RULE13]
        take     = (i_avs_read | i_avs_write) && (s_q.bus == rtd_mux_pkg::bus_idle);
        take_rd  = take && i_avs_read;
        take_wr  = take && i_avs_write && !i_avs_read;
        for (int c = 0; c < 4; c++) begin
            o_chan_active[c] = s_q.cfg_done && (2'(c) <= s_q.chan_last);  // [RULE2]
        end
        fault = 4'h0;
        fault[`RTD_FAULT_SHORT] = s_q.short_flag[next_ptr];  // [RULE17]
        fault[`RTD_FAULT_POWER] = !i_power_ok;  // [RULE17]
        events = 4'h0;
        events[`RTD_ST_CONV]  = i_conv_valid && o_chan_active[i_conv_chan];
        events[`RTD_ST_SHORT] = events[`RTD_ST_CONV] && i_conv_short;
        events[`RTD_ST_POWER] = !i_power_ok;
        events[`RTD_ST_WRAP]  = i_scan_strobe && !s_q.hold && wrap;
        rd_mux = 32'h0;
        case (i_avs_address)
            `RTD_OFS_CONFIG: begin
                rd_mux[`RTD_CFG_LAST_LSB +: 2] = s_q.chan_last;
                rd_mux[`RTD_CFG_TYPE_LSB +: 3] = s_q.sensor;
                rd_mux[`RTD_CFG_FMT_LSB +: 2]  = s_q.fmt;
            end
            `RTD_OFS_STATUS: rd_mux[3:0] = s_q.status;
            `RTD_OFS_MASK:   rd_mux[3:0] = s_q.mask;
            `RTD_OFS_CTRL:   rd_mux[`RTD_CTRL_HOLD] = s_q.hold;
            `RTD_OFS_WORD:   rd_mux = s_q.word;
            default:         rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Straps are caught once, on the first edge after reset release
        if (!s_q.cfg_done) begin
            s_d.cfg_done  = 1'b1;
            s_d.chan_last = strap_last;  // [RULE1]
            if (i_sensor_type_sel_2) begin
                s_d.sensor = rtd_mux_pkg::sensor_platinum_1000;  // [RULE3]
            end else begin
                s_d.sensor = rtd_mux_pkg::sensor_e'({1'b0, i_sensor_type_sel_1,
                                                     i_sensor_type_sel_0});  // [RULE3] [RULE4]
            end
            s_d.fmt = rtd_mux_pkg::fmt_e'({i_units_sel_1, i_units_sel_0});  // [RULE7]
        end

        // Store a finished conversion only for an active channel
        if (events[`RTD_ST_CONV]) begin  // [RULE2]
            s_d.reading[i_conv_chan]    = conv_data;  // [RULE9]
            s_d.short_flag[i_conv_chan] = i_conv_short;  // [RULE17]
        end

        // One channel per host scan; value and id load in the same edge
        if (i_scan_strobe && !s_q.hold) begin  // [RULE12]
            s_d.ptr = next_ptr;  // [RULE13]
            s_d.word = 32'h0;
            s_d.word[15:0] = s_q.reading[next_ptr];  // [RULE11] [RULE16]
            s_d.word[`RTD_WORD_ID_LSB +: 2] = next_ptr;  // [RULE18]
            s_d.word[`RTD_WORD_FAULT_LSB +: 4] = fault;  // [RULE16] [RULE17]
        end

        // Read clears status; an event in the same cycle still sets its bit
        if (take_rd && i_avs_address == `RTD_OFS_STATUS) begin
            s_d.status = events;
        end else begin
            s_d.status = s_q.status | events;
        end

        if (take_wr && i_avs_byteenable[0]) begin
            case (i_avs_address)
                `RTD_OFS_MASK: s_d.mask = i_avs_writedata[3:0];
                `RTD_OFS_CTRL: s_d.hold = i_avs_writedata[`RTD_CTRL_HOLD];
                default:       s_d.hold = s_q.hold;
            endcase
        end

        // Fixed one wait state keeps read data registered
        case (s_q.bus)
            rtd_mux_pkg::bus_idle: begin
                if (take) begin
                    s_d.bus   = rtd_mux_pkg::bus_ack;
                    s_d.rdata = take_rd ? rd_mux : 32'h0;
                end
            end
            rtd_mux_pkg::bus_ack: s_d.bus = rtd_mux_pkg::bus_idle;
            default:              s_d.bus = rtd_mux_pkg::bus_idle;
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q            <= '0;
            s_q.chan_last  <= `RTD_RST_CHAN_LAST;  // [RULE1]
            s_q.sensor     <= rtd_mux_pkg::sensor_e'(`RTD_RST_SENSOR);  // [RULE5]
            s_q.fmt        <= rtd_mux_pkg::fmt_e'(`RTD_RST_FMT);  // [RULE8]
            s_q.ptr        <= `RTD_RST_PTR;
            s_q.mask       <= `RTD_RST_MASK;
            s_q.bus        <= rtd_mux_pkg::bus_idle;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign o_input_word      = s_q.word;
    assign o_avs_readdata    = s_q.rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) && (s_q.bus == rtd_mux_pkg::bus_idle);
    assign o_irq             = |(s_q.status & s_q.mask);

endmodule : rtd_input_mux

// >>> verilog/rtd_mux_pkg.sv
package rtd_mux_pkg;

    // Encoding follows the type straps, select 0 in the low bit
    typedef enum logic [2:0] {
        sensor_cu10                  = 3'h0,
        sensor_cu25                  = 3'h1,
        sensor_platinum_100_american = 3'h2,
        sensor_platinum_100_euro     = 3'h3,
        sensor_platinum_1000         = 3'h4
    } sensor_e;

    // Encoding follows the format straps, {select 1, select 0}
    typedef enum logic [1:0] {
        fmt_twos_c = 2'h0,
        fmt_twos_f = 2'h1,
        fmt_mag_c  = 2'h2,
        fmt_mag_f  = 2'h3
    } fmt_e;

    typedef enum logic {
        bus_idle = 1'b0,
        bus_ack  = 1'b1
    } bus_state_e;

    typedef struct packed {
        logic             cfg_done;
        logic [1:0]       chan_last;
        sensor_e          sensor;
        fmt_e             fmt;
        logic [3:0][15:0] reading;
        logic [3:0]       short_flag;
        logic [1:0]       ptr;
        logic [31:0]      word;
        logic [3:0]       status;
        logic [3:0]       mask;
        logic             hold;
        bus_state_e       bus;
        logic [31:0]      rdata;
    } rtd_state_s;

endpackage : rtd_mux_pkg

// >>> verilog/rtd_mux_regs.svh
`ifndef RTD_MUX_REGS_SVH
`define RTD_MUX_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTD_OFS_CONFIG          8'h00
`define RTD_OFS_STATUS          8'h04
`define RTD_OFS_MASK            8'h08
`define RTD_OFS_CTRL            8'h0c
`define RTD_OFS_WORD            8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTD_WORD_SIGN_BIT       15
`define RTD_WORD_ID_LSB         16
`define RTD_WORD_FAULT_LSB      18
`define RTD_FAULT_SHORT         0
`define RTD_FAULT_POWER         1
`define RTD_CFG_LAST_LSB        0
`define RTD_CFG_TYPE_LSB        2
`define RTD_CFG_FMT_LSB         5
`define RTD_ST_CONV             0
`define RTD_ST_SHORT            1
`define RTD_ST_POWER            2
`define RTD_ST_WRAP             3
`define RTD_CTRL_HOLD           0

// ----------------------------------------------------------------------------
// Reset values (factory strap settings, then rotation pointer and interrupt mask)
// ----------------------------------------------------------------------------
`define RTD_RST_CHAN_LAST       2'h3
`define RTD_RST_SENSOR          3'h3
`define RTD_RST_FMT             2'h3
`define RTD_RST_PTR             2'h3
`define RTD_RST_MASK            4'h0

// ----------------------------------------------------------------------------
// Conversion constants
// ----------------------------------------------------------------------------
`define RTD_DEV_FRAC            20
`define RTD_K_FRAC              8
`define RTD_ALPHA_EURO_PPM      3850
`define RTD_ALPHA_AMER_PPM      3920
`define RTD_ALPHA_P1000_PPM     3850
`define RTD_ALPHA_COPPER_PPM    4270
`define RTD_K_FROM_PPM(p)       (20'(((64'h1 << `RTD_K_FRAC) * 64'd10000000) / 64'(p)))
`define RTD_MAG_MAX             32'sd32767
`define RTD_F_OFFSET_TENTHS     32'sd320

`endif

// >>> verilog/rtd_temp_convert.sv
`timescale 1ns/100ps
`include "rtd_mux_regs.svh"

module rtd_temp_convert (
    input  wire logic [23:0]         i_dev,
    input  wire rtd_mux_pkg::sensor_e i_sensor,
    input  wire rtd_mux_pkg::fmt_e    i_fmt,
    output logic      [15:0]         o_data
);

    logic        [19:0] k;
    logic signed [44:0] prod;
    logic signed [31:0] tc;
    logic signed [31:0] t;
    logic signed [31:0] tn;
    logic               neg;

    // ------------------------------------------------------------------------
    // Linearisation and unit scaling
    // ------------------------------------------------------------------------
    always_comb begin
        // One gain per sensor type, shared by all channels
        case (i_sensor)
            rtd_mux_pkg::sensor_platinum_100_euro:     k = `RTD_K_FROM_PPM(`RTD_ALPHA_EURO_PPM);  // [RULE6]
            rtd_mux_pkg::sensor_platinum_100_american: k = `RTD_K_FROM_PPM(`RTD_ALPHA_AMER_PPM);  // [RULE6]
            rtd_mux_pkg::sensor_platinum_1000:         k = `RTD_K_FROM_PPM(`RTD_ALPHA_P1000_PPM);
            default:                                   k = `RTD_K_FROM_PPM(`RTD_ALPHA_COPPER_PPM);
        endcase
        prod = $signed(i_dev) * $signed({1'b0, k});
        // Tenths of a degree Celsius; floor rounding of the shift is accepted
        tc = {{15{prod[44]}}, prod[44:28]};  // [RULE10]
        if (i_fmt == rtd_mux_pkg::fmt_twos_f || i_fmt == rtd_mux_pkg::fmt_mag_f) begin
            t = ((tc * 32'sd9) / 32'sd5) + `RTD_F_OFFSET_TENTHS;  // [RULE9]
        end else begin
            t = tc;  // [RULE9]
        end
        // Symmetric clamp keeps both formats inside fifteen magnitude bits
        if (t > `RTD_MAG_MAX) begin
            t = `RTD_MAG_MAX;
        end else if (t < -`RTD_MAG_MAX) begin
            t = -`RTD_MAG_MAX;
        end
        neg = t[31];
        tn  = -t;
        if (i_fmt == rtd_mux_pkg::fmt_mag_f || i_fmt == rtd_mux_pkg::fmt_mag_c) begin
            o_data = {neg, neg ? tn[14:0] : t[14:0]};  // [RULE11] [RULE16]
        end else begin
            o_data = t[15:0];  // [RULE11]
        end
    end

endmodule : rtd_temp_convert
